/* spgc_pkg.sv */
// constants and state types for the serial module register bank
package spgc_pkg;
    localparam int unsigned AW = 7;
    localparam int unsigned DW = 32;
    // register byte offsets, all multiples of four, with holes at 7'h2c-7'h34 and 7'h60
    localparam logic [6:0] OFS_GC0 = 7'h00;
    localparam logic [6:0] OFS_GC1 = 7'h04;
    localparam logic [6:0] OFS_INT_EN = 7'h08;
    localparam logic [6:0] OFS_INT_LVL = 7'h0c;
    localparam logic [6:0] OFS_FLAG = 7'h10;
    localparam logic [6:0] OFS_PIN_FUNC = 7'h14;
    localparam logic [6:0] OFS_PIN_DIR = 7'h18;
    localparam logic [6:0] OFS_PIN_IN = 7'h1c;
    localparam logic [6:0] OFS_PIN_OUT = 7'h20;
    localparam logic [6:0] OFS_PIN_SET = 7'h24;
    localparam logic [6:0] OFS_PIN_CLR = 7'h28;
    localparam logic [6:0] OFS_TX_PLAIN = 7'h38;
    localparam logic [6:0] OFS_TX_FMT = 7'h3c;
    localparam logic [6:0] OFS_RX_BUF = 7'h40;
    localparam logic [6:0] OFS_RX_DBG = 7'h44;
    localparam logic [6:0] OFS_DELAYS = 7'h48;
    localparam logic [6:0] OFS_DEF_SEL = 7'h4c;
    localparam logic [6:0] OFS_FMT0 = 7'h50;
    localparam logic [6:0] OFS_FMT1 = 7'h54;
    localparam logic [6:0] OFS_FMT2 = 7'h58;
    localparam logic [6:0] OFS_FMT3 = 7'h5c;
    localparam logic [6:0] OFS_INT_VEC = 7'h64;
    // slots of the plain read/write configuration words
    localparam int unsigned NCFG = 10;
    localparam int unsigned CFG_INT_EN = 0;
    localparam int unsigned CFG_INT_LVL = 1;
    localparam int unsigned CFG_PIN_FUNC = 2;
    localparam int unsigned CFG_PIN_DIR = 3;
    localparam int unsigned CFG_DELAYS = 4;
    localparam int unsigned CFG_DEF_SEL = 5;
    localparam int unsigned CFG_FMT0 = 6;
    // field positions
    localparam int unsigned GC0_SOFT_RUN = 0;
    localparam int unsigned GC1_MASTER = 0;
    localparam int unsigned GC1_INT_CLK = 1;
    localparam int unsigned GC1_POWER_DOWN = 8;
    localparam int unsigned GC1_LOOPBACK = 16;
    localparam int unsigned GC1_ENABLE = 24;
    localparam int unsigned IE_DMA_REQ_EN = 16;
    localparam int unsigned PF_DATA_OUT = 10;
    localparam int unsigned PF_DATA_IN = 11;
    localparam int unsigned RX_EMPTY_BIT = 31;
    localparam int unsigned TXW = 16;
    // reset values
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [TXW-1:0] TX_RESET = 16'h0000;

    typedef struct packed {
        logic soft_run;
        logic enable;
        logic loopback;
        logic power_down;
        logic int_clk;
        logic master;
        logic [NCFG-1:0][DW-1:0] cfg;
        logic [TXW-1:0] tx_plain;
        logic [DW-1:0] tx_fmt;
        logic tx_strobe;
        logic [TXW-1:0] rx_buf;
        logic rx_empty;
        logic [TXW-1:0] rx_hold;
        logic hold_valid;
        logic [DW-1:0] rdata;
    } spgc_state_s;

    typedef struct packed {
        logic [DW-1:0] value;
    } spgc_word_s;
endpackage

/* spgc_word.sv */
// status word with write, write-one-set, write-one-clear and hardware set
`timescale 1ns/1ps
`default_nettype none
module spgc_word (
    input wire logic sys_clk, // module clock
    input wire logic sys_rst, // synchronous reset, high
    input wire logic hold_zero, // forces the word to zero
    input wire logic wr_val_en, // plain write strobe
    input wire logic wr_set_en, // write-one-set strobe
    input wire logic wr_clr_en, // write-one-clear strobe
    input wire logic [31:0] wdata, // write data
    input wire logic [31:0] hw_set, // hardware set pulses
    output logic [31:0] value // current word
);
    spgc_pkg::spgc_word_s q, d;

    // hardware set is applied after the writes so an event never loses to a write-one-clear; hold_zero wins over it
    always_comb begin
        d = q;
        if (wr_val_en) begin
            d.value = wdata;
        end
        if (wr_set_en) begin
            d.value = d.value | wdata;
        end
        if (wr_clr_en) begin
            d.value = d.value & ~wdata;
        end
        d.value = d.value | hw_set;
        if (hold_zero) begin
            d.value = spgc_pkg::CFG_RESET;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign value = q.value;
endmodule
`default_nettype wire

/* spgc_regs.sv */
// register decode and global control of the serial module
`timescale 1ns/1ps
`default_nettype none
module spgc_regs (
    input wire logic sys_clk, // module clock, 200 MHz
    input wire logic sys_rst, // synchronous reset, high
    input wire logic [6:0] reg_addr, // register byte address
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [31:0] reg_rdata, // read data, cycle after strobe
    input wire logic [31:0] pin_level, // sampled pin levels
    input wire logic [31:0] vector_in, // interrupt vector from engine
    input wire logic [31:0] flag_set, // engine flag event pulses
    input wire logic rx_load, // engine delivers a received word
    input wire logic [15:0] rx_word, // received word
    output logic core_reset, // engine held in reset
    output logic xfer_permit, // engine may start a transfer
    output logic state_clear, // engine forces shift state to defaults
    output logic power_down, // engine in power-down
    output logic int_clk_sel, // internal clock generation
    output logic master_sel, // master role
    output logic loop_active, // transmit looped into receive
    output logic clk_hold_idle, // clock pin held at idle level
    output logic data_pins_float, // data pins released
    output logic dma_request_enable, // dma requests allowed
    output logic [31:0] int_enable, // interrupt enable word
    output logic [31:0] int_level, // interrupt level word
    output logic [31:0] pin_func, // pin function word
    output logic [31:0] pin_dir, // pin direction word
    output logic [31:0] pin_out, // pin output value word
    output logic [31:0] flags, // flag word
    output logic [31:0] delays, // transfer delay word
    output logic [31:0] def_sel, // default select level word
    output logic [127:0] formats, // four format words, 0 lowest
    output logic [15:0] tx_word, // word to transmit
    output logic [15:0] tx_format, // format bits of last OFS_TX_FMT word
    output logic tx_written // pulse: new transmit word
);
    spgc_pkg::spgc_state_s q, d;
    logic aligned;
    logic wr_ok;
    logic rd_ok;
    logic live_wr;
    logic [31:0] rd_word;
    logic [31:0] rx_view;
    logic flag_hold;
    logic pin_hold;

    assign aligned = (reg_addr[1:0] == 2'h0);
    assign wr_ok = reg_wr && aligned;
    assign rd_ok = reg_rd && aligned;
    // only the reset word is writable while the module is held in reset
    assign live_wr = wr_ok && q.soft_run;
    assign rx_view = {q.rx_empty, 15'h0000, q.rx_buf};

    // flags are cleared by enable low as well as by soft reset; taken from
    // the next state so the clear lands on the edge the bit drops
    assign flag_hold = !d.soft_run || !d.enable;
    assign pin_hold = !d.soft_run;

    spgc_word u_flags (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .hold_zero(flag_hold),
        .wr_val_en(1'b0),
        .wr_set_en(1'b0),
        .wr_clr_en(live_wr && reg_addr == spgc_pkg::OFS_FLAG),
        .wdata(reg_wdata),
        .hw_set(flag_set),
        .value(flags)
    );

    // set and clear aliases avoid read-modify-write races between tasks
    spgc_word u_pin_out (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .hold_zero(pin_hold),
        .wr_val_en(live_wr && reg_addr == spgc_pkg::OFS_PIN_OUT),
        .wr_set_en(live_wr && reg_addr == spgc_pkg::OFS_PIN_SET),
        .wr_clr_en(live_wr && reg_addr == spgc_pkg::OFS_PIN_CLR),
        .wdata(reg_wdata),
        .hw_set(32'h0000_0000),
        .value(pin_out)
    );

    // read multiplexer; holes and misaligned addresses give zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (reg_addr)
            spgc_pkg::OFS_GC0: begin
                rd_word[spgc_pkg::GC0_SOFT_RUN] = q.soft_run;
            end
            spgc_pkg::OFS_GC1: begin
                rd_word[spgc_pkg::GC1_ENABLE] = q.enable;
                rd_word[spgc_pkg::GC1_LOOPBACK] = q.loopback;
                rd_word[spgc_pkg::GC1_POWER_DOWN] = q.power_down;
                rd_word[spgc_pkg::GC1_INT_CLK] = q.int_clk;
                rd_word[spgc_pkg::GC1_MASTER] = q.master;
            end
            spgc_pkg::OFS_INT_EN: begin
                rd_word = q.cfg[spgc_pkg::CFG_INT_EN];
            end
            spgc_pkg::OFS_INT_LVL: begin
                rd_word = q.cfg[spgc_pkg::CFG_INT_LVL];
            end
            spgc_pkg::OFS_FLAG: begin
                rd_word = flags;
            end
            spgc_pkg::OFS_PIN_FUNC: begin
                rd_word = q.cfg[spgc_pkg::CFG_PIN_FUNC];
            end
            spgc_pkg::OFS_PIN_DIR: begin
                rd_word = q.cfg[spgc_pkg::CFG_PIN_DIR];
            end
            spgc_pkg::OFS_PIN_IN: begin
                rd_word = pin_level;
            end
            spgc_pkg::OFS_PIN_OUT, spgc_pkg::OFS_PIN_SET,
            spgc_pkg::OFS_PIN_CLR: begin
                rd_word = pin_out;
            end
            spgc_pkg::OFS_TX_PLAIN: begin
                rd_word = {16'h0000, q.tx_plain};
            end
            spgc_pkg::OFS_TX_FMT: begin
                rd_word = q.tx_fmt;
            end
            spgc_pkg::OFS_RX_BUF, spgc_pkg::OFS_RX_DBG: begin
                rd_word = rx_view;
            end
            spgc_pkg::OFS_DELAYS: begin
                rd_word = q.cfg[spgc_pkg::CFG_DELAYS];
            end
            spgc_pkg::OFS_DEF_SEL: begin
                rd_word = q.cfg[spgc_pkg::CFG_DEF_SEL];
            end
            spgc_pkg::OFS_FMT0, spgc_pkg::OFS_FMT1,
            spgc_pkg::OFS_FMT2, spgc_pkg::OFS_FMT3: begin
                rd_word = q.cfg[spgc_pkg::CFG_FMT0 + 32'(reg_addr[3:2])];
            end
            spgc_pkg::OFS_INT_VEC: begin
                rd_word = vector_in;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // next state: writes, receive path, then the forcing conditions
    always_comb begin
        d = q;
        d.tx_strobe = 1'b0;
        d.rdata = rd_ok ? rd_word : 32'h0000_0000;
        if (wr_ok && reg_addr == spgc_pkg::OFS_GC0) begin
            d.soft_run = reg_wdata[spgc_pkg::GC0_SOFT_RUN];
        end
        if (live_wr) begin
            case (reg_addr)
                spgc_pkg::OFS_GC1: begin
                    d.enable = reg_wdata[spgc_pkg::GC1_ENABLE];
                    d.loopback = reg_wdata[spgc_pkg::GC1_LOOPBACK];
                    d.power_down = reg_wdata[spgc_pkg::GC1_POWER_DOWN];
                    d.int_clk = reg_wdata[spgc_pkg::GC1_INT_CLK];
                    d.master = reg_wdata[spgc_pkg::GC1_MASTER];
                end
                spgc_pkg::OFS_INT_EN: begin
                    d.cfg[spgc_pkg::CFG_INT_EN] = reg_wdata;
                end
                spgc_pkg::OFS_INT_LVL: begin
                    d.cfg[spgc_pkg::CFG_INT_LVL] = reg_wdata;
                end
                spgc_pkg::OFS_PIN_FUNC: begin
                    d.cfg[spgc_pkg::CFG_PIN_FUNC] = reg_wdata;
                end
                spgc_pkg::OFS_PIN_DIR: begin
                    d.cfg[spgc_pkg::CFG_PIN_DIR] = reg_wdata;
                end
                spgc_pkg::OFS_DELAYS: begin
                    d.cfg[spgc_pkg::CFG_DELAYS] = reg_wdata;
                end
                spgc_pkg::OFS_DEF_SEL: begin
                    d.cfg[spgc_pkg::CFG_DEF_SEL] = reg_wdata;
                end
                spgc_pkg::OFS_FMT0, spgc_pkg::OFS_FMT1,
                spgc_pkg::OFS_FMT2, spgc_pkg::OFS_FMT3: begin
                    d.cfg[spgc_pkg::CFG_FMT0 + 32'(reg_addr[3:2])] =
                        reg_wdata;
                end
                spgc_pkg::OFS_TX_PLAIN: begin
                    d.tx_plain = reg_wdata[15:0];
                    d.tx_strobe = 1'b1;
                end
                spgc_pkg::OFS_TX_FMT: begin
                    d.tx_fmt = reg_wdata;
                    d.tx_plain = reg_wdata[15:0];
                    d.tx_strobe = 1'b1;
                end
                default: begin
                    d.tx_strobe = 1'b0;
                end
            endcase
        end
        // reading the buffer empties it or refills it from the hidden word
        if (rd_ok && reg_addr == spgc_pkg::OFS_RX_BUF) begin
            if (q.hold_valid) begin
                d.rx_buf = q.rx_hold;
                d.hold_valid = 1'b0;
            end else begin
                d.rx_empty = 1'b1;
            end
        end
        // a word arriving with the read lands, load wins over the clear
        if (rx_load) begin
            if (d.rx_empty) begin
                d.rx_buf = rx_word;
                d.rx_empty = 1'b0;
            end else begin
                d.rx_hold = rx_word; // overwrites an unread hidden word
                d.hold_valid = 1'b1;
            end
        end
        // soft reset: everything but the reset bit back to reset state;
        // next-state test avoids a cycle of stale words after the drop
        if (!d.soft_run) begin
            d.enable = 1'b0;
            d.loopback = 1'b0;
            d.power_down = 1'b0;
            d.int_clk = 1'b0;
            d.master = 1'b0;
            d.cfg = '0;
            d.tx_fmt = spgc_pkg::CFG_RESET;
        end
        // enable low puts data paths to defaults and drops writes there, except tx_fmt[31:16]
        if (!d.enable) begin
            d.tx_plain = spgc_pkg::TX_RESET;
            d.tx_fmt[15:0] = spgc_pkg::TX_RESET;
            d.tx_strobe = 1'b0;
            d.rx_buf = spgc_pkg::TX_RESET;
            d.rx_hold = spgc_pkg::TX_RESET;
            d.hold_valid = 1'b0;
            d.rx_empty = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q <= '0;
            q.rx_empty <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // control outputs to the serial engine
    assign reg_rdata = q.rdata;
    assign core_reset = !q.soft_run;
    assign xfer_permit = q.soft_run && q.enable && !q.power_down;
    assign state_clear = !q.enable;
    assign power_down = q.power_down;
    assign int_clk_sel = q.int_clk;
    assign master_sel = q.master;
    // loop-back only takes hold when both data pins are functional
    assign loop_active = q.loopback
        && q.cfg[spgc_pkg::CFG_PIN_FUNC][spgc_pkg::PF_DATA_OUT]
        && q.cfg[spgc_pkg::CFG_PIN_FUNC][spgc_pkg::PF_DATA_IN];
    assign clk_hold_idle = loop_active;
    assign data_pins_float = loop_active;
    // passed as written; ordering against enable is left to software
    assign dma_request_enable =
        q.cfg[spgc_pkg::CFG_INT_EN][spgc_pkg::IE_DMA_REQ_EN];
    assign int_enable = q.cfg[spgc_pkg::CFG_INT_EN];
    assign int_level = q.cfg[spgc_pkg::CFG_INT_LVL];
    assign pin_func = q.cfg[spgc_pkg::CFG_PIN_FUNC];
    assign pin_dir = q.cfg[spgc_pkg::CFG_PIN_DIR];
    assign delays = q.cfg[spgc_pkg::CFG_DELAYS];
    assign def_sel = q.cfg[spgc_pkg::CFG_DEF_SEL];
    assign formats = {q.cfg[spgc_pkg::CFG_FMT0 + 3],
                      q.cfg[spgc_pkg::CFG_FMT0 + 2],
                      q.cfg[spgc_pkg::CFG_FMT0 + 1],
                      q.cfg[spgc_pkg::CFG_FMT0]};
    assign tx_word = q.tx_plain;
    assign tx_format = q.tx_fmt[31:16];
    assign tx_written = q.tx_strobe;
endmodule
`default_nettype wire

/* spgc_regs_properties.sv */
// assertion checker for the serial module register bank
`timescale 1ns/1ps
`default_nettype none
module spgc_regs_properties (
    input wire logic sys_clk, // clock
    input wire logic sys_rst, // sync reset
    input wire logic [6:0] reg_addr, // address
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [31:0] reg_rdata, // read data
    input wire logic core_reset, // engine reset
    input wire logic xfer_permit, // transfer permit
    input wire logic state_clear, // state clear
    input wire logic power_down, // power-down
    input wire logic int_clk_sel, // clock select
    input wire logic master_sel, // master role
    input wire logic loop_active, // loop-back
    input wire logic clk_hold_idle, // clock idles
    input wire logic dma_request_enable, // dma enable
    input wire logic [31:0] int_enable, // enable word
    input wire logic [31:0] pin_func, // function word
    input wire logic [31:0] flags, // flag word
    input wire logic [15:0] tx_word // transmit word
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    // holes in the map and misaligned addresses must answer zero
    logic hole;
    assign hole = reg_addr[1:0] != 2'h0 || reg_addr > 7'h64 ||
        reg_addr inside {7'h2c, 7'h30, 7'h34, 7'h60};
    property p_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("stray read data");
    property p_hole;
        reg_rd && hole |=> reg_rdata == 32'h0;
    endproperty
    a_hole: assert property (p_hole) else $error("unmapped read");
    property p_res0;
        reg_rd && reg_addr == 7'h00 |=> reg_rdata[31:1] == 31'h0;
    endproperty
    a_res0: assert property (p_res0) else $error("gc0 reserved");
    property p_res1;
        reg_rd && reg_addr == 7'h04 |=> (reg_rdata & 32'hfefe_fefc) == 32'h0;
    endproperty
    a_res1: assert property (p_res1) else $error("gc1 reserved");
    property p_soft;
        reg_wr && reg_addr == 7'h00 |=> core_reset == !$past(reg_wdata[0]);
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset bit");
    // soft reset keeps master, clock select, power-down and interrupt enable at reset value
    property p_held;
        core_reset |-> !master_sel && !int_clk_sel && !power_down &&
            int_enable == 32'h0;
    endproperty
    a_held: assert property (p_held) else $error("held regs moved");
    property p_gc1;
        reg_wr && reg_addr == 7'h04 && !core_reset |=>
            master_sel == $past(reg_wdata[0]) &&
            int_clk_sel == $past(reg_wdata[1]) &&
            power_down == $past(reg_wdata[8]);
    endproperty
    a_gc1: assert property (p_gc1) else $error("gc1 fields");
    property p_permit;
        xfer_permit == (!core_reset && !state_clear && !power_down);
    endproperty
    a_permit: assert property (p_permit) else $error("permit");
    property p_clear;
        state_clear |-> flags == 32'h0 && tx_word == 16'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear state");
    property p_loop;
        loop_active == clk_hold_idle &&
            (!loop_active || pin_func[11:10] == 2'b11);
    endproperty
    a_loop: assert property (p_loop) else $error("loop-back");
    property p_dma;
        dma_request_enable == int_enable[16];
    endproperty
    a_dma: assert property (p_dma) else $error("dma enable");
    c_loop: cover property (loop_active);
    c_enable: cover property ($fell(state_clear));
    c_hole: cover property (reg_rd && hole);
endmodule
bind spgc_regs spgc_regs_properties u_props (.sys_clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_reset, .xfer_permit,
    .state_clear, .power_down, .int_clk_sel, .master_sel, .loop_active,
    .clk_hold_idle, .dma_request_enable, .int_enable, .pin_func, .flags,
    .tx_word);
`default_nettype wire

/* testbench.sv */
// self-checking bench for the serial module register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk, sys_rst, reg_wr, reg_rd, rx_load;
    logic [6:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, pin_level, vector_in, flag_set;
    logic [31:0] flags, int_enable, pin_func, seed, w, f;
    logic [15:0] rx_word, tx_word;
    logic core_reset, xfer_permit, state_clear, power_down;
    logic int_clk_sel, master_sel, loop_active, dma_request_enable;
    logic [31:0] int_level, pin_dir, pin_out, delays, def_sel;
    logic [127:0] formats;
    logic [15:0] tx_format;
    logic clk_hold_idle, data_pins_float, tx_written;
    int fail_count, comparisons;
    logic [6:0] cfg [10] = '{7'h08, 7'h0c, 7'h14, 7'h18, 7'h48, 7'h4c,
        7'h50, 7'h54, 7'h58, 7'h5c};
    logic [6:0] holes [6] = '{7'h2c, 7'h34, 7'h60, 7'h68, 7'h7c, 7'h09};
    logic [31:0] corner [4] = '{32'h0, 32'hffff_ffff, 32'h0100_0000,
        32'h0101_0100};
    spgc_regs DUT (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .pin_level, .vector_in, .flag_set, .rx_load,
        .rx_word, .core_reset, .xfer_permit, .state_clear, .power_down,
        .int_clk_sel, .master_sel, .loop_active, .clk_hold_idle,
        .data_pins_float, .dma_request_enable, .int_enable, .int_level,
        .pin_func, .pin_dir, .pin_out, .flags, .delays, .def_sel, .formats,
        .tx_word, .tx_format, .tx_written);
    // 200 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // control outputs expected after a gc1 write, pin pair functional
    function automatic logic [31:0] ctl_exp(input logic [31:0] v);
        return {24'h0, v[16], v[16], v[8], v[1], v[0], !v[24],
            v[24] & !v[8], v[16]};
    endfunction
    // the output port that mirrors a plain configuration word
    function automatic logic [31:0] port_of(input logic [6:0] a);
        case (a)
            7'h08: return int_enable;
            7'h0c: return int_level;
            7'h14: return pin_func;
            7'h18: return pin_dir;
            7'h48: return delays;
            7'h4c: return def_sel;
            default: return formats[32*a[3:2] +: 32];
        endcase
    endfunction
    task automatic chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    // write, then let the edge's updates land before anyone looks
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rc(input string n, input logic [6:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(n, reg_rdata, e);
    endtask
    task automatic pulse(input logic [31:0] fs, input logic [15:0] wd);
        @(posedge sys_clk);
        flag_set <= fs;
        rx_load <= 1'b1;
        rx_word <= wd;
        @(posedge sys_clk);
        flag_set <= 32'h0;
        rx_load <= 1'b0;
        #1;
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        #100000;
        fail_count++;
        conclude();
    end
    initial begin
        seed = 32'h82a9;
        fail_count = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h0;
        reg_wdata = 32'h0;
        flag_set = 32'h0;
        rx_load = 1'b0;
        rx_word = 16'h0;
        pin_level = nxt();
        vector_in = nxt();
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        chk("core_reset", {31'h0, core_reset}, 32'h1);
        rc("rx_empty", 7'h40, 32'h8000_0000);
        wr(7'h04, 32'h0101_0103);
        rc("gc1_held", 7'h04, 32'h0);
        wr(7'h00, 32'hffff_ffff);
        rc("gc0", 7'h00, 32'h1);
        rc("pin_in", 7'h1c, pin_level);
        rc("vector", 7'h64, vector_in);
        $display("test soft reset done");
        // each plain word keeps what was written; holes stay empty
        foreach (cfg[i]) begin
            w = nxt();
            wr(cfg[i], w);
            rc("cfg", cfg[i], w);
            chk("cfg_port", port_of(cfg[i]), w);
        end
        foreach (holes[i]) begin
            wr(holes[i], nxt());
            rc("hole", holes[i], 32'h0);
        end
        w = nxt();
        f = nxt();
        wr(7'h20, w);
        wr(7'h24, f);
        wr(7'h28, w & f);
        chk("pin_out", pin_out, w ^ f);
        rc("pin_alias", 7'h24, w ^ f);
        $display("test map done");
        wr(7'h14, 32'h0000_0c00);
        for (int i = 0; i < 12; i++) begin
            w = (i < 4) ? corner[i] : nxt();
            wr(7'h04, w);
            rc("gc1", 7'h04, w & 32'h0101_0103);
            chk("ctl", {24'h0, data_pins_float, clk_hold_idle, power_down,
                int_clk_sel, master_sel, state_clear, xfer_permit,
                loop_active}, ctl_exp(w));
        end
        wr(7'h14, 32'h0000_0400);
        wr(7'h04, 32'h0001_0001);
        chk("loop_half", {30'h0, loop_active, data_pins_float}, 32'h0);
        $display("test control done");
        // enable, then dma, fill both receive words, then disable
        wr(7'h04, 32'h0100_0001);
        wr(7'h08, 32'h0001_0000);
        chk("dma", {31'h0, dma_request_enable}, 32'h1);
        w = nxt();
        f = nxt();
        wr(7'h3c, f);
        chk("tx_written", {31'h0, tx_written}, 32'h1);
        chk("tx_format", {16'h0, tx_format}, {16'h0, f[31:16]});
        wr(7'h38, w);
        chk("tx_word", {16'h0, tx_word}, {16'h0, w[15:0]});
        pulse(f, w[31:16]);
        pulse(32'h0, ~w[31:16]);
        wr(7'h10, f & 32'h0000_ffff);
        chk("flags_w1c", flags, f & 32'hffff_0000);
        rc("rx_view", 7'h44, {16'h0, w[31:16]});
        wr(7'h04, 32'h0000_0001);
        chk("flags_clr", flags, 32'h0);
        chk("tx_clr", {16'h0, tx_word}, 32'h0);
        rc("rx_clr", 7'h40, 32'h8000_0000);
        rc("hidden_clr", 7'h40, 32'h8000_0000);
        rc("tx_plain_clr", 7'h38, 32'h0);
        wr(7'h38, w);
        chk("tx_blocked", {31'h0, tx_written}, 32'h0);
        wr(7'h00, 32'h0);
        chk("re_reset", {31'h0, core_reset}, 32'h1);
        rc("int_held", 7'h08, 32'h0);
        $display("test enable clear done");
        conclude();
    end
endmodule
`default_nettype wire
